// ### inc/csad_pkg.sv
package csad_pkg;
    // memory-mapped configuration region at its reset location
    localparam logic [19:0] HIGH_PAGE = 20'hFFFEF;
    localparam int unsigned REGION_BITS = 12;
    // alias window must lie in the lowest 1 Gbyte
    localparam logic [1:0] LOW_GB_TOP = 2'h0;
    // fixed I/O addresses (dword aligned, byte lane picks the port)
    localparam logic [15:0] ALIAS_IO_ADDR = 16'hFFFC;
    localparam logic [15:0] PCI_INDEX_IO_ADDR = 16'h0CF8;
    localparam logic [15:0] PCI_DATA_IO_ADDR = 16'h0CFC;
    localparam logic [15:0] RTC_IO_ADDR = 16'h0070;
    localparam int unsigned RTC_INDEX_LANE = 0;
    localparam int unsigned RTC_DATA_LANE = 1;
    localparam logic [3:0] DWORD_BE = 4'hF;
    // alias register layout
    localparam int unsigned ALIAS_EN_BIT = 31;
    localparam int unsigned ALIAS_BASE_LSB = 12;
    localparam int unsigned ALIAS_BASE_MSB = 29;
    localparam logic [31:0] ALIAS_WR_MASK = 32'hBFFF_F000;
    // reset values
    localparam logic [31:0] ALIAS_RESET = 32'h0000_0000;
    localparam logic [31:0] PCI_INDEX_RESET = 32'h0000_0000;
    localparam logic [7:0] RTC_INDEX_RESET = 8'h00;
endpackage

// ### verification/csad_decoder_tb.sv
module csad_decoder_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic req, is_io, wr, fwd_wr, cfg_sel, cfg_alias, pci_sel, rtc_sel, pass_sel, local_done;
    logic [31:0] addr, wdata, fwd_addr, fwd_wdata, pci_index, local_rdata;
    logic [3:0] be, fwd_be;
    logic [11:0] cfg_offset;
    logic [7:0] rtc_index;
    logic [4:0] sel;
    int fail_count = 0;
    int checked = 0;

    assign sel = {cfg_sel, pci_sel, rtc_sel, pass_sel, local_done};
    always #50 ref_clk = ~ref_clk;

    csad_host_model host (.clk(ref_clk), .req(req), .is_io(is_io), .wr(wr), .addr(addr), .be(be),
        .wdata(wdata));

    csad_decoder uut (.REF_CLK(ref_clk), .RST_N(rst_n), .HOST_REQ(req), .HOST_IS_IO(is_io),
        .HOST_WR(wr), .HOST_ADDR(addr), .HOST_BE(be), .HOST_WDATA(wdata), .FWD_WR(fwd_wr),
        .FWD_ADDR(fwd_addr), .FWD_BE(fwd_be), .FWD_WDATA(fwd_wdata), .CFG_SEL(cfg_sel),
        .CFG_ALIAS(cfg_alias), .CFG_OFFSET(cfg_offset), .PCI_SEL(pci_sel), .PCI_INDEX(pci_index),
        .RTC_SEL(rtc_sel), .RTC_INDEX(rtc_index), .PASS_SEL(pass_sel), .LOCAL_DONE(local_done),
        .LOCAL_RDATA(local_rdata));

    task automatic chk(input logic [31:0] got, exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // select order: cfg, pci, rtc, pass, local
    task automatic go(input logic [1:0] k, input logic [31:0] a, d, input logic [3:0] b, input logic [4:0] s);
        host.access(k, a, d, b);
        chk({27'h0, sel}, {27'h0, s});
    endtask

    task automatic t_reset();
        repeat (10) @(posedge ref_clk);
        #1;
        rst_n = 1'h1;
        chk({27'h0, sel}, 32'h0);
        chk(pci_index, 32'h0);
        chk({24'h0, rtc_index}, 32'h0);
    endtask

    task automatic t_high();
        go(2'h0, 32'hFFFEF123, 32'h0, 4'hF, 5'h10);
        chk({19'h0, cfg_alias, cfg_offset}, 32'h123);
        go(2'h1, 32'hFFFEFFFC, 32'h0, 4'h3, 5'h10);
        go(2'h0, 32'hFFFEFC20, 32'h0, 4'h1, 5'h10);
        go(2'h0, 32'hFFFEEFFC, 32'h0, 4'hF, 5'h02);
        go(2'h0, 32'hFFFF0000, 32'h0, 4'hF, 5'h02);
        go(2'h2, 32'hFFFEF120, 32'h0, 4'hF, 5'h02);
    endtask

    task automatic t_alias();
        go(2'h0, 32'h00005010, 32'h0, 4'hF, 5'h02);
        go(2'h3, 32'h0000FFFC, 32'hC0005ABC, 4'hF, 5'h01);
        go(2'h2, 32'h0000FFFC, 32'h0, 4'hF, 5'h01);
        chk(local_rdata, 32'h80005000);
        go(2'h0, 32'h00005010, 32'h0, 4'hF, 5'h10);
        chk({19'h0, cfg_alias, cfg_offset}, 32'h1010);
        go(2'h0, 32'h40005010, 32'h0, 4'hF, 5'h02);
        go(2'h0, 32'hFFFEF010, 32'h0, 4'hF, 5'h10);
        chk({31'h0, cfg_alias}, 32'h0);
        go(2'h3, 32'h0000FFFC, 32'hBFFFF000, 4'hF, 5'h01);
        go(2'h1, 32'h3FFFF004, 32'h0, 4'hF, 5'h10);
        go(2'h3, 32'h0000FFFC, 32'h0, 4'h1, 5'h02);
    endtask

    task automatic t_pci();
        go(2'h3, 32'h00000CF8, 32'h80001234, 4'hF, 5'h01);
        chk(pci_index, 32'h80001234);
        go(2'h2, 32'h00000CF8, 32'h0, 4'hF, 5'h01);
        chk(local_rdata, 32'h80001234);
        go(2'h3, 32'h00000CFC, 32'h55AA, 4'hF, 5'h08);
        go(2'h2, 32'h00000CFC, 32'h0, 4'h1, 5'h02);
        go(2'h0, 32'h00000CF8, 32'h0, 4'hF, 5'h02);
    endtask

    task automatic t_rtc();
        go(2'h3, 32'h00000070, 32'h0D, 4'h1, 5'h01);
        chk({24'h0, rtc_index}, 32'h0D);
        go(2'h2, 32'h00000070, 32'h0, 4'h2, 5'h04);
        go(2'h3, 32'h00000070, 32'h3C2A, 4'h3, 5'h04);
        chk({24'h0, rtc_index}, 32'h2A);
        go(2'h2, 32'h00000070, 32'h0, 4'h1, 5'h01);
        chk(local_rdata, 32'h2A);
        go(2'h2, 32'h00000074, 32'h0, 4'h1, 5'h02);
    endtask

    task automatic t_pass();
        go(2'h1, 32'h12345678, 32'hCAFE0001, 4'h6, 5'h02);
        chk(fwd_addr, 32'h12345678);
        chk(fwd_wdata, 32'hCAFE0001);
        chk({27'h0, fwd_wr, fwd_be}, 32'h16);
    endtask

    task automatic results();
        if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        t_reset();
        t_high();
        t_alias();
        t_pci();
        t_rtc();
        t_pass();
        results();
    end

    // hang guard, far beyond the run
    initial
    begin
        #100000;
        fail_count++;
        results();
    end
endmodule

// ### verification/csad_host_model.sv
module csad_host_model (
    // clock
    input wire logic clk,
    // host cycle
    output logic req,
    output logic is_io,
    output logic wr,
    output logic [31:0] addr,
    output logic [3:0] be,
    output logic [31:0] wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        req = 1'h0;
        is_io = 1'h0;
        wr = 1'h0;
        addr = 32'h0;
        be = 4'h0;
        wdata = 32'h0;
    end

    // one cycle; k is {io, write}; released addr, be and wdata show the inverse
    task automatic access(input logic [1:0] k, input logic [31:0] a, d, input logic [3:0] b);
        @(posedge clk);
        #1;
        req = 1'h1;
        is_io = k[1];
        wr = k[0];
        addr = a;
        be = b;
        wdata = d;
        @(posedge clk);
        #1;
        req = 1'h0;
        addr = ~a;
        be = ~b;
        wdata = ~d;
    endtask
endmodule

// ### verilog/csad_decoder.sv
// Notes on behaviour
// RULE_01 - after reset the config region is the 4-Kbyte window at FFFEF000h.
// RULE_02 - alias register places a second 4-Kbyte window in the lowest 1 Gbyte.
// RULE_03 - with the alias on, the high-memory window still decodes the region.
// RULE_04 - PCI config reached by index at I/O 0CF8h, data at 0CFCh, 32-bit.
// RULE_05 - RTC registers reached by index at I/O 0070h, data at 0071h.
// RULE_06 - alias and PCI ports are 32-bit; other direct-mapped registers 8-bit.
// RULE_07 - direct-mapped registers sit at fixed I/O addresses, never relocated.
// RULE_08 - region registers live in memory space, 8, 16 or 32 bits wide.
// RULE_09 - every other peripheral register is routed to the memory-mapped region.
// RULE_10 - accesses hitting nothing pass on unchanged, selecting no config register.
module csad_decoder (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // host cycle
    input wire logic HOST_REQ,
    input wire logic HOST_IS_IO,
    input wire logic HOST_WR,
    input wire logic [31:0] HOST_ADDR,
    input wire logic [3:0] HOST_BE,
    input wire logic [31:0] HOST_WDATA,
    // forwarded cycle
    output logic FWD_WR,
    output logic [31:0] FWD_ADDR,
    output logic [3:0] FWD_BE,
    output logic [31:0] FWD_WDATA,
    // selects
    output logic CFG_SEL,
    output logic CFG_ALIAS,
    output logic [11:0] CFG_OFFSET,
    output logic PCI_SEL,
    output logic [31:0] PCI_INDEX,
    output logic RTC_SEL,
    output logic [7:0] RTC_INDEX,
    output logic PASS_SEL,
    // locally answered ports
    output logic LOCAL_DONE,
    output logic [31:0] LOCAL_RDATA
);
    logic [31:0] alias_r;
    logic [31:0] pci_index_r;
    logic [7:0] rtc_index_r;
    logic hit_high;
    logic hit_alias;
    logic hit_alias_reg;
    logic hit_pci_index;
    logic hit_pci_data;
    logic hit_rtc_index;
    logic hit_rtc_data;
    logic hit_any;
    logic [31:0] alias_nxt;
    logic [31:0] pci_index_nxt;
    logic [7:0] rtc_index_nxt;

    // region decode in memory space
    always_comb
    begin
        // RULE_01 reset location
        hit_high = HOST_REQ && !HOST_IS_IO && HOST_ADDR[31:csad_pkg::REGION_BITS] == csad_pkg::HIGH_PAGE;
        // RULE_02 alias window
        hit_alias = HOST_REQ && !HOST_IS_IO && alias_r[csad_pkg::ALIAS_EN_BIT]
            && HOST_ADDR[31:30] == csad_pkg::LOW_GB_TOP
            && HOST_ADDR[csad_pkg::ALIAS_BASE_MSB:csad_pkg::ALIAS_BASE_LSB]
               == alias_r[csad_pkg::ALIAS_BASE_MSB:csad_pkg::ALIAS_BASE_LSB];
    end

    // fixed I/O decode
    always_comb
    begin
        // RULE_07 fixed port addresses
        // RULE_06 dword-only wide ports
        hit_alias_reg = HOST_REQ && HOST_IS_IO && HOST_ADDR[15:2] == csad_pkg::ALIAS_IO_ADDR[15:2]
            && HOST_BE == csad_pkg::DWORD_BE;
        // RULE_04 pci index and data
        hit_pci_index = HOST_REQ && HOST_IS_IO && HOST_ADDR[15:2] == csad_pkg::PCI_INDEX_IO_ADDR[15:2]
            && HOST_BE == csad_pkg::DWORD_BE;
        hit_pci_data = HOST_REQ && HOST_IS_IO && HOST_ADDR[15:2] == csad_pkg::PCI_DATA_IO_ADDR[15:2]
            && HOST_BE == csad_pkg::DWORD_BE;
        // RULE_05 rtc index and data bytes
        hit_rtc_index = HOST_REQ && HOST_IS_IO && HOST_ADDR[15:2] == csad_pkg::RTC_IO_ADDR[15:2]
            && HOST_BE[csad_pkg::RTC_INDEX_LANE] && !HOST_BE[csad_pkg::RTC_DATA_LANE];
        hit_rtc_data = HOST_REQ && HOST_IS_IO && HOST_ADDR[15:2] == csad_pkg::RTC_IO_ADDR[15:2]
            && HOST_BE[csad_pkg::RTC_DATA_LANE];
        // RULE_03 high window wins nothing away from alias
        hit_any = hit_high || hit_alias || hit_alias_reg || hit_pci_index || hit_pci_data
            || hit_rtc_index || hit_rtc_data;
    end

    // next values of the port registers
    always_comb
    begin
        alias_nxt = alias_r;
        pci_index_nxt = pci_index_r;
        rtc_index_nxt = rtc_index_r;
        // RULE_02 base kept inside 1 Gbyte
        if (hit_alias_reg && HOST_WR)
        begin
            alias_nxt = HOST_WDATA & csad_pkg::ALIAS_WR_MASK;
        end
        if (hit_pci_index && HOST_WR)
        begin
            pci_index_nxt = HOST_WDATA;
        end
        // RULE_05 index byte at 0070h
        if (HOST_REQ && HOST_IS_IO && HOST_WR && HOST_ADDR[15:2] == csad_pkg::RTC_IO_ADDR[15:2]
            && HOST_BE[csad_pkg::RTC_INDEX_LANE])
        begin
            rtc_index_nxt = HOST_WDATA[7:0];
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            alias_r <= csad_pkg::ALIAS_RESET;
            pci_index_r <= csad_pkg::PCI_INDEX_RESET;
            rtc_index_r <= csad_pkg::RTC_INDEX_RESET;
        end
        else
        begin
            alias_r <= alias_nxt;
            pci_index_r <= pci_index_nxt;
            rtc_index_r <= rtc_index_nxt;
        end
    end

    // select outputs, one cycle after the request
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            CFG_SEL <= 1'h0;
            CFG_ALIAS <= 1'h0;
            CFG_OFFSET <= 12'h000;
            PCI_SEL <= 1'h0;
            RTC_SEL <= 1'h0;
            PASS_SEL <= 1'h0;
            LOCAL_DONE <= 1'h0;
        end
        else
        begin
            // RULE_08 region in memory space
            // RULE_09 all region registers via one select
            CFG_SEL <= hit_high || hit_alias;
            CFG_ALIAS <= hit_alias && !hit_high;
            CFG_OFFSET <= HOST_ADDR[csad_pkg::REGION_BITS-1:0];
            PCI_SEL <= hit_pci_data;
            RTC_SEL <= hit_rtc_data;
            // RULE_10 miss passes on
            PASS_SEL <= HOST_REQ && !hit_any;
            LOCAL_DONE <= hit_alias_reg || hit_pci_index || hit_rtc_index;
        end
    end

    // forwarded cycle and local read data
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            FWD_WR <= 1'h0;
            FWD_ADDR <= 32'h0000_0000;
            FWD_BE <= 4'h0;
            FWD_WDATA <= 32'h0000_0000;
            LOCAL_RDATA <= 32'h0000_0000;
        end
        else
        begin
            FWD_WR <= HOST_REQ && HOST_WR;
            FWD_ADDR <= HOST_ADDR;
            FWD_BE <= HOST_BE;
            FWD_WDATA <= HOST_WDATA;
            if (hit_alias_reg)
            begin
                LOCAL_RDATA <= alias_r;
            end
            else if (hit_pci_index)
            begin
                LOCAL_RDATA <= pci_index_r;
            end
            else if (hit_rtc_index)
            begin
                LOCAL_RDATA <= {24'h00_0000, rtc_index_r};
            end
            else
            begin
                LOCAL_RDATA <= 32'h0000_0000;
            end
        end
    end

    // indices as seen by the selected data port
    assign PCI_INDEX = pci_index_r;
    assign RTC_INDEX = rtc_index_r;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    property p_high_window;
        HOST_REQ && !HOST_IS_IO && HOST_ADDR[31:12] == 20'hFFFEF
            |=> CFG_SEL && !CFG_ALIAS && CFG_OFFSET == $past(HOST_ADDR[11:0]) && !PASS_SEL;
    endproperty
    a_high_window: assert property (p_high_window) else $error("high window missed"); // RULE_01

    property p_alias_window;
        HOST_REQ && !HOST_IS_IO && alias_r[31] && HOST_ADDR[31:30] == 2'h0
            && HOST_ADDR[29:12] == alias_r[29:12] |=> CFG_SEL && CFG_ALIAS;
    endproperty
    a_alias_window: assert property (p_alias_window) else $error("alias window missed"); // RULE_02

    property p_alias_in_low_gb;
        alias_r[30] == 1'h0 && alias_r[11:0] == 12'h000;
    endproperty
    a_alias_in_low_gb: assert property (p_alias_in_low_gb) else $error("alias outside 1 Gbyte"); // RULE_02

    property p_high_with_alias;
        alias_r[31] && HOST_REQ && !HOST_IS_IO && HOST_ADDR[31:12] == 20'hFFFEF ##1 1'h1
            |-> CFG_SEL;
    endproperty
    a_high_with_alias: assert property (p_high_with_alias) else $error("high window lost under alias"); // RULE_03

    property p_pci_index_write;
        HOST_REQ && HOST_IS_IO && HOST_WR && HOST_ADDR[15:0] == 16'h0CF8 && HOST_BE == 4'hF
            |=> PCI_INDEX == $past(HOST_WDATA) && LOCAL_DONE;
    endproperty
    a_pci_index_write: assert property (p_pci_index_write) else $error("pci index not stored"); // RULE_04

    property p_pci_data;
        HOST_REQ && HOST_IS_IO && HOST_ADDR[15:0] == 16'h0CFC && HOST_BE == 4'hF |=> PCI_SEL && !PASS_SEL;
    endproperty
    a_pci_data: assert property (p_pci_data) else $error("pci data not selected"); // RULE_04

    property p_pci_narrow;
        HOST_REQ && HOST_IS_IO && HOST_ADDR[15:2] == 14'h033F && HOST_BE != 4'hF |=> !PCI_SEL && PASS_SEL;
    endproperty
    a_pci_narrow: assert property (p_pci_narrow) else $error("narrow pci access decoded"); // RULE_06

    property p_rtc_data;
        HOST_REQ && HOST_IS_IO && HOST_ADDR[15:2] == 14'h001C && HOST_BE[1]
            |=> RTC_SEL ##1 !RTC_SEL || $past(HOST_REQ);
    endproperty
    a_rtc_data: assert property (p_rtc_data) else $error("rtc data not selected"); // RULE_05

    property p_miss_pass;
        HOST_REQ && !HOST_IS_IO && HOST_ADDR[31:12] != 20'hFFFEF && !alias_r[31]
            |=> PASS_SEL && !CFG_SEL && !PCI_SEL && !RTC_SEL;
    endproperty
    a_miss_pass: assert property (p_miss_pass) else $error("miss not passed on"); // RULE_10

    property p_one_target;
        // exactly one answer per request, none without one
        $onehot0({CFG_SEL, PCI_SEL, RTC_SEL, PASS_SEL, LOCAL_DONE})
            && (|{CFG_SEL, PCI_SEL, RTC_SEL, PASS_SEL, LOCAL_DONE}) == $past(HOST_REQ);
    endproperty
    a_one_target: assert property (p_one_target) else $error("two targets selected"); // RULE_09

    c_alias_hit: cover property (CFG_SEL && CFG_ALIAS);
    c_pci_data: cover property (PCI_SEL);
    c_rtc_data: cover property (RTC_SEL);
    c_pass: cover property (PASS_SEL);
    c_local: cover property (LOCAL_DONE);
endmodule
